// >>> verilog/bimd_pkg.sv
// Package of constants and types for the bridge input mode decoder.
package bimd_pkg;

  // ---------------------------------------------------------------
  // Mode codes.
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BIMD_HALF = 2'h0,  // Independent half-bridges.
    BIMD_PHEN = 2'h1,  // Phase/enable H-bridge.
    BIMD_SOL  = 2'h3,  // Split solenoid, Gray neighbour of PWM.
    BIMD_PWM  = 2'h2   // Two-input PWM H-bridge.
  } bimd_mode_t;

  // Four pin levels map onto the four mode codes in order.
  localparam logic [1:0] BIMD_LVL1 = 2'h0;
  localparam logic [1:0] BIMD_LVL2 = 2'h1;
  localparam logic [1:0] BIMD_LVL3 = 2'h2;
  localparam logic [1:0] BIMD_LVL4 = 2'h3;

  // Timing configuration widths and reset values.
  localparam int BIMD_TW = 8;
  localparam logic [7:0] BIMD_TDRV_RST = 8'h10;
  localparam logic [7:0] BIMD_TDEAD_RST = 8'h02;

  // Gate phase per gate: dead-time wait, peak drive, hold.
  typedef enum logic [1:0] {
    BIMD_G_HOLD = 2'h0,  // Steady state, hold or strong pull-down.
    BIMD_G_DEAD = 2'h1,  // Waiting out dead time before turn-on.
    BIMD_G_PEAK = 2'h3   // Peak current, monitor blanking.
  } bimd_gph_t;

  // Gate set for both half-bridges; index 0 is half-bridge one.
  typedef struct packed {
    logic [1:0] high_gate;
    logic [1:0] low_gate;
  } bimd_gates_t;

  // Pin inputs travelling together.
  typedef struct packed {
    logic ctrl_input_one;
    logic ctrl_input_two;
    logic [1:0] float_pin_n;
    logic driver_off_pin;
  } bimd_pins_t;

endpackage : bimd_pkg

// >>> verilog/bimd_decoder.sv
// Bridge input mode decoder with per-gate drive timing.
`timescale 1ns/10ps
module bimd_decoder (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire bimd_pkg::bimd_pins_t pins,
  input wire logic serial_variant,
  input wire logic [1:0] bridge_mode_sel,
  input wire logic [1:0] mode_pin_level,
  input wire logic ctrl_one_source_sel,
  input wire logic ctrl_two_source_sel,
  input wire logic reg_ctrl_one,
  input wire logic reg_ctrl_two,
  input wire logic [1:0] reg_float_bit,
  input wire logic freewheel_sel,
  input wire logic driver_enable_bit,
  input wire logic [7:0] drive_time_cfg,
  input wire logic [7:0] dead_time_cfg,
  output bimd_pkg::bimd_gates_t gate_on,
  output bimd_pkg::bimd_gates_t gate_peak,
  output bimd_pkg::bimd_gates_t gate_strong,
  output logic [1:0] fault_blank,
  output logic [1:0] float_eff
);
  import bimd_pkg::*;

  // ---------------------------------------------------------------
  // Overview.
  // ---------------------------------------------------------------
  // Pins pass a two-flop synchroniser. A table decode then picks the
  // wanted state of each of the four gates for the selected mode.
  // A small per-gate sequencer times each change: an optional dead
  // time before any turn-on, a peak-current window after every change,
  // and a hold or strong pull-down state once that window has closed.
  // Configuration inputs come from logic on this clock and are used
  // directly. Only the pins cross in from outside the domain.
  // The decode is combinational, so every gate command moves on one
  // clock edge, whatever the mode.

  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------
  // Two flops per pin; only the second stage is decoded.
  bimd_pins_t meta_r;  // First stage, read by second stage only.
  bimd_pins_t sync_r;  // Second stage, safe to decode.
  // Float pins idle high, so reset synchronisers to the not-floated state.
  localparam bimd_pins_t PINS_RST = 5'h06;

  // Both stages move together on every edge.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= PINS_RST;
      sync_r <= PINS_RST;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Input selection.
  // ---------------------------------------------------------------
  // Mode comes from the register field or the strapped pin level.
  wire [1:0] mode_code = serial_variant ? bridge_mode_sel : mode_pin_level;
  wire bimd_mode_t mode = bimd_mode_t'(mode_code);
  // Register control only applies when the register path exists.
  wire in_one = (serial_variant && ctrl_one_source_sel) ? reg_ctrl_one
                                                        : sync_r.ctrl_input_one;
  wire in_two = (serial_variant && ctrl_two_source_sel) ? reg_ctrl_two
                                                        : sync_r.ctrl_input_two;
  // Each bridge uses its own register bit, not the one-bit copy of the misprint.
  wire [1:0] float_reg = serial_variant ? reg_float_bit : 2'h0;
  wire float_eff_a = !sync_r.float_pin_n[0] || float_reg[0];
  wire float_eff_b = !sync_r.float_pin_n[1] || float_reg[1];
  // The off pin and enable bit float the bridge in every mode.
  wire drv_kill = sync_r.driver_off_pin || (serial_variant && !driver_enable_bit);
  // Freewheel side; held low-side when no register path exists.
  wire fw_high = serial_variant && freewheel_sel;
  // A pin-configured part has no register path, so every register input but
  // drive_time_cfg and dead_time_cfg is masked there. Stale register values cannot then leak in
  // when the same logic is built without the serial interface.
  // The trade-off is one extra gate level on each selected input.

  // ---------------------------------------------------------------
  // Mode decode.
  // ---------------------------------------------------------------
  // The decode is a plain table, written case by case so that each
  // branch can be read against its mode. Driver-off and the enable bit
  // are applied last, after the table, so that they win in every mode.
  bimd_gates_t cmd;  // Requested gate states before timing.

  // Table decode per mode; float pins only matter in half-bridge mode.
  always_comb begin
    cmd = '0;
    unique case (mode)
      BIMD_HALF: begin
        // Float wins over control input.
        cmd.high_gate[0] = !float_eff_a && in_one;
        cmd.low_gate[0] = !float_eff_a && !in_one;
        cmd.high_gate[1] = !float_eff_b && in_two;
        cmd.low_gate[1] = !float_eff_b && !in_two;
      end
      BIMD_PHEN: begin
        if (!in_one) begin
          cmd.high_gate = {2{fw_high}};
          cmd.low_gate = {2{!fw_high}};
        end else if (in_two) begin
          cmd.high_gate = 2'h1;  // forward
          cmd.low_gate = 2'h2;
        end else begin
          cmd.high_gate = 2'h2;  // reverse
          cmd.low_gate = 2'h1;
        end
      end
      BIMD_PWM: begin
        unique case ({in_one, in_two})
          2'h0: cmd = '0;  // coast
          2'h1: begin
            cmd.high_gate = 2'h2;  // reverse
            cmd.low_gate = 2'h1;
          end
          2'h2: begin
            cmd.high_gate = 2'h1;  // forward
            cmd.low_gate = 2'h2;
          end
          2'h3: begin
            cmd.high_gate = {2{fw_high}};
            cmd.low_gate = {2{!fw_high}};
          end
        endcase
      end
      BIMD_SOL: begin
        // Only high gate one and low gate two respond.
        cmd.high_gate[0] = in_one;
        cmd.low_gate[1] = in_two;
      end
    endcase
    // Float inputs are not consulted outside half-bridge mode.
    if (drv_kill) begin
      cmd = '0;
    end
  end

  // ---------------------------------------------------------------
  // Per-gate timing: dead time, peak drive, hold.
  // ---------------------------------------------------------------
  // Flattened gate vectors; index 0..1 high gates, 2..3 low gates.
  wire [3:0] req = {cmd.low_gate, cmd.high_gate};
  logic [3:0] on_r;  // Gate currently driven on.
  logic [3:0] peak_r;  // Gate in its peak-current window.
  logic [3:0] strong_r;  // Gate held off with strong pull-down.
  logic [3:0] dead_r;  // Gate waiting out dead time.

  // Each gate has its own small sequencer. Turn-off is never delayed,
  // because a late turn-off is what causes shoot-through. Turn-on may
  // wait out the dead time and then the partner gate's turn-off.
  // One shared down-counter serves both the dead and drive intervals.
  // This saves a counter per gate, at the cost of one phase at a time.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gl_gate
      // The opposite gate in the same half-bridge.
      localparam int OPP = (g + 2) % 4;
      logic [7:0] cnt_r;  // Shared dead and drive timer.
      bimd_gph_t ph_r;  // Phase of this gate.
      logic on_q;  // This gate's own on flag, one driver per bit.
      wire change = req[g] != on_r[g] && !(dead_r[g] && req[g]);
      // With a nonzero dead time, turning on waits it out and then for the partner to be off.
      wire start_dead = change && req[g] && dead_time_cfg != 8'h00;
      wire cnt_done = cnt_r <= 8'h01;

      // One timer serves the dead interval and then the drive interval.
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          ph_r <= BIMD_G_HOLD;
          cnt_r <= 8'h00;
          on_q <= 1'b0;
        end else if (!req[g] && (on_r[g] || dead_r[g])) begin
          // Turn-off is immediate and reloads a fresh drive window.
          ph_r <= BIMD_G_PEAK;
          cnt_r <= drive_time_cfg;
          on_q <= 1'b0;
        end else if (start_dead) begin
          ph_r <= BIMD_G_DEAD;
          cnt_r <= dead_time_cfg;
        end else if (change && req[g]) begin
          ph_r <= BIMD_G_PEAK;
          cnt_r <= drive_time_cfg;
          on_q <= 1'b1;
        end else if (ph_r == BIMD_G_DEAD) begin
          // Break before make: the partner must be fully off first.
          if (cnt_done && !on_r[OPP]) begin
            ph_r <= BIMD_G_PEAK;
            cnt_r <= drive_time_cfg;
            on_q <= 1'b1;
          end else if (!cnt_done) begin
            cnt_r <= cnt_r - 8'h01;
          end
        end else if (ph_r == BIMD_G_PEAK) begin
          if (cnt_done) begin
            ph_r <= BIMD_G_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
      end

      assign on_r[g] = on_q;
      assign dead_r[g] = ph_r == BIMD_G_DEAD;
      assign peak_r[g] = ph_r == BIMD_G_PEAK;
      // Off gates in the hold phase, past their drive window and not in dead time, get the strong pull-down.
      assign strong_r[g] = !on_r[g] && ph_r == BIMD_G_HOLD;

      // Never both gates of one half-bridge on together.
      a_no_shoot: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !(on_r[g] && on_r[OPP]))
        else $error("Both gates of a half-bridge on.");

      // Turn-off never waits for the sequencer.
      a_off_fast: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !req[g] |=> !on_r[g])
        else $error("Gate turn-off was delayed.");

      // A gate waiting out dead time stays off while its partner is on.
      a_dead_wait: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (dead_r[g] && on_r[OPP]) |=> !on_r[g])
        else $error("Gate turned on before its partner was off.");

      // With no dead time a requested gate turns on at the next edge.
      a_zero_dead: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (req[g] && !on_r[g] && !dead_r[g] && dead_time_cfg == 8'h00) |=> on_r[g])
        else $error("Gate turn-on late with no dead time.");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Registered outputs.
  // ---------------------------------------------------------------
  // Every output is a flop; blanking follows the peak window.
  // The internal vectors keep high gates in bits 0..1 and low gates in
  // bits 2..3, so they are regrouped field by field into the struct.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gate_on <= '0;
      gate_peak <= '0;
      gate_strong <= '1;
      fault_blank <= 2'h0;
      float_eff <= 2'h0;
    end else begin
      gate_on <= bimd_gates_t'({on_r[1:0], on_r[3:2]});
      gate_peak <= bimd_gates_t'({peak_r[1:0], peak_r[3:2]});
      gate_strong <= bimd_gates_t'({strong_r[1:0], strong_r[3:2]});
      fault_blank <= {peak_r[1] | peak_r[3], peak_r[0] | peak_r[2]};
      float_eff <= {float_eff_b, float_eff_a};
    end
  end

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  a_float_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_HALF && float_eff_a) |=> !on_r[0] && !on_r[2])
    else $error("Floated half-bridge one still driven.");
  a_kill_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    drv_kill |=> on_r == 4'h0)
    else $error("Driver off did not clear gates.");
  a_sol_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode == BIMD_SOL |-> cmd.high_gate[1] == 1'b0 && cmd.low_gate[0] == 1'b0)
    else $error("Inactive solenoid gate commanded.");
  a_coast_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_PWM && !in_one && !in_two) |-> cmd == '0)
    else $error("Coast did not turn gates off.");
  a_fw_side: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_PHEN && !in_one && !drv_kill) |-> cmd.low_gate == {2{!fw_high}})
    else $error("Freewheel on wrong side.");
  a_hb_nofloat: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_PWM && in_one && !in_two && !drv_kill) |-> cmd.high_gate == 2'h1)
    else $error("Float affected H-bridge mode.");
  a_sync_delay: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##2 sync_r == $past(pins, 2))
    else $error("Pin synchroniser depth wrong.");
  a_blank_out: assert property (@(posedge sys_clk) disable iff (!reset_n)
    peak_r[0] |=> fault_blank[0])
    else $error("Blanking missed peak window.");

  // Half-bridge one high gate follows its input when not floated.
  a_half_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_HALF && !drv_kill && !float_eff_a) |-> cmd.high_gate[0] == in_one)
    else $error("Half-bridge high gate wrong.");

  // Half-bridge one low gate is the inverse of its input.
  a_half_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_HALF && !drv_kill && !float_eff_a) |-> cmd.low_gate[0] == !in_one)
    else $error("Half-bridge low gate wrong.");

  // A floated half-bridge two has both gates off.
  a_float_b_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_HALF && float_eff_b) |-> cmd.high_gate[1] == 1'b0
      && cmd.low_gate[1] == 1'b0)
    else $error("Floated half-bridge two still driven.");

  // Phase high with enable drives forward.
  a_phen_fwd: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_PHEN && in_one && in_two && !drv_kill) |-> cmd.high_gate == 2'h1
      && cmd.low_gate == 2'h2)
    else $error("Forward drive decoded wrongly.");

  // Phase low with enable drives reverse.
  a_phen_rev: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_PHEN && in_one && !in_two && !drv_kill) |-> cmd.high_gate == 2'h2
      && cmd.low_gate == 2'h1)
    else $error("Reverse drive decoded wrongly.");

  // Both inputs high in two-input mode freewheel on the selected side.
  a_pwm_fw: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_PWM && in_one && in_two && !drv_kill) |-> cmd.high_gate == {2{fw_high}}
      && cmd.low_gate == {2{!fw_high}})
    else $error("Two-input freewheel wrong.");

  // The active solenoid gates follow their own inputs.
  a_sol_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode == BIMD_SOL && !drv_kill) |-> cmd.high_gate[0] == in_one
      && cmd.low_gate[1] == in_two)
    else $error("Solenoid gate does not follow input.");

  // A pin-configured part always freewheels low-side.
  a_fw_default: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !serial_variant |-> !fw_high)
    else $error("High-side freewheel without register path.");

  // Register float bits are masked without a register path.
  a_reg_masked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !serial_variant |-> float_reg == 2'h0)
    else $error("Register float bit used on pin part.");

  // The float output shows the effective float one edge later.
  a_float_out: assert property (@(posedge sys_clk) disable iff (!reset_n)
    1'b1 |=> float_eff == $past({float_eff_b, float_eff_a}))
    else $error("Float output lost its value.");

  // Gate outputs keep each gate in its own struct field.
  a_gate_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
    1'b1 |=> gate_on.high_gate == $past(on_r[1:0]) && gate_on.low_gate == $past(on_r[3:2]))
    else $error("Gate output mapping wrong.");

  // Half-bridge two blanking follows its peak window.
  a_blank_two: assert property (@(posedge sys_clk) disable iff (!reset_n)
    peak_r[1] |=> fault_blank[1])
    else $error("Blanking missed second peak window.");

endmodule : bimd_decoder

// >>> sim/bimd_mcu.sv
// Controller model that drives the decoder's control and float pins.
`timescale 1ns/10ps
module bimd_mcu (
  input wire logic sys_clk,
  input wire bimd_pkg::bimd_pins_t req,
  output bimd_pkg::bimd_pins_t pins
);
  import bimd_pkg::*;
  // ---------------------------------------------------------------
  // Pin driver.
  // ---------------------------------------------------------------
  // Float pins start released (high); a controller never leaves them unknown.
  initial pins = '{1'b0, 1'b0, 2'h3, 1'b0};
  // Pins move only on the falling edge, well clear of the sampling edge.
  always @(negedge sys_clk) begin
    pins <= req;
  end
endmodule : bimd_mcu

// >>> sim/tb_top.sv
// Self-checking testbench for the bridge input mode decoder.
`timescale 1ns/10ps
module tb_top;
  import bimd_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, serial_variant = 1'b1;
  logic [1:0] bridge_mode_sel = 2'h0, mode_pin_level = 2'h0, reg_float_bit = 2'h0;
  logic ctrl_one_source_sel = 1'b0, ctrl_two_source_sel = 1'b0;
  logic reg_ctrl_one = 1'b0, reg_ctrl_two = 1'b0, freewheel_sel = 1'b0;
  logic driver_enable_bit = 1'b1;
  logic [7:0] drive_time_cfg = 8'h04, dead_time_cfg = 8'h00;
  bimd_pins_t req = '{1'b0, 1'b0, 2'h3, 1'b0};
  bimd_pins_t pins;
  bimd_gates_t gate_on, gate_peak, gate_strong;
  logic [1:0] fault_blank, float_eff;
  int failures = 0, checks_done = 0;
  bimd_mcu mcu (.sys_clk(sys_clk), .req(req), .pins(pins));
  bimd_decoder uut (.sys_clk(sys_clk), .reset_n(reset_n), .pins(pins),
    .serial_variant(serial_variant), .bridge_mode_sel(bridge_mode_sel),
    .mode_pin_level(mode_pin_level), .ctrl_one_source_sel(ctrl_one_source_sel),
    .ctrl_two_source_sel(ctrl_two_source_sel), .reg_ctrl_one(reg_ctrl_one),
    .reg_ctrl_two(reg_ctrl_two), .reg_float_bit(reg_float_bit),
    .freewheel_sel(freewheel_sel), .driver_enable_bit(driver_enable_bit),
    .drive_time_cfg(drive_time_cfg), .dead_time_cfg(dead_time_cfg),
    .gate_on(gate_on), .gate_peak(gate_peak), .gate_strong(gate_strong),
    .fault_blank(fault_blank), .float_eff(float_eff));
  // ---------------------------------------------------------------
  // Shared helpers.
  // ---------------------------------------------------------------
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // Gate word in struct order: {high two, high one, low two, low one}.
  function automatic logic [3:0] g(input logic h1, l1, h2, l2);
    return {h2, h1, l2, l1};
  endfunction : g
  // Ten cycles cover two sync stages plus decode with zero dead time.
  task automatic drive(input logic i1, i2, input logic [1:0] fz_n, input logic off);
    req = '{i1, i2, fz_n, off};
    repeat (10) @(negedge sys_clk);
  endtask : drive
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // ---------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------
  // Independent half-bridges: float priority, own float bits, drive window.
  task automatic t_half;
    int n;
    logic seen_blank;
    bridge_mode_sel = 2'h0;
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 2; i++) begin
        drive(i[0], i[0], {f[0], f[0]}, 1'b0);
        chk("half", gate_on, f[0] ? g(i[0], !i[0], i[0], !i[0]) : 4'h0);
      end
    end
    drive(1'b1, 1'b0, 2'h2, 1'b0);
    chk("half_float_a", gate_on, g(1'b0, 1'b0, 1'b0, 1'b1));
    chk("float_eff_a", float_eff, 4'h1);
    reg_float_bit = 2'h2;
    drive(1'b1, 1'b1, 2'h3, 1'b0);
    chk("half_reg_b", gate_on, g(1'b1, 1'b0, 1'b0, 1'b0));
    chk("float_eff_b", float_eff, 4'h2);
    reg_float_bit = 2'h0;
    drive(1'b0, 1'b0, 2'h3, 1'b0);
    n = 0;
    seen_blank = 1'b0;
    req = '{1'b1, 1'b0, 2'h3, 1'b0};
    repeat (16) begin
      @(negedge sys_clk);
      n += int'(gate_peak.high_gate[0]);
      seen_blank |= fault_blank[0];
    end
    chk("peak_len", n[3:0], drive_time_cfg[3:0]);
    chk("blank", {3'h0, seen_blank}, 4'h1);
    chk("strong", gate_strong, ~gate_on);
    $display("test half done");
  endtask : t_half
  // Phase/enable: freewheel side, direction; float pins held asserted.
  task automatic t_phen;
    bridge_mode_sel = 2'h1;
    for (int w = 0; w < 2; w++) begin
      freewheel_sel = w[0];
      drive(1'b0, 1'b1, 2'h0, 1'b0);
      chk("phen_fw", gate_on, g(w[0], !w[0], w[0], !w[0]));
    end
    freewheel_sel = 1'b0;
    drive(1'b1, 1'b0, 2'h0, 1'b0);
    chk("phen_rev", gate_on, g(1'b0, 1'b1, 1'b1, 1'b0));
    drive(1'b1, 1'b1, 2'h0, 1'b0);
    chk("phen_fwd", gate_on, g(1'b1, 1'b0, 1'b0, 1'b1));
    drive(1'b1, 1'b1, 2'h0, 1'b1);
    chk("phen_off", gate_on, 4'h0);
    $display("test phen done");
  endtask : t_phen
  // Two-input mode: every code with both freewheel sides, then disables.
  task automatic t_pwm;
    logic [3:0] e;
    bridge_mode_sel = 2'h2;
    for (int c = 0; c < 8; c++) begin
      freewheel_sel = c[2];
      case (c[1:0])
        2'h0: e = 4'h0;
        2'h1: e = g(1'b0, 1'b1, 1'b1, 1'b0);
        2'h2: e = g(1'b1, 1'b0, 1'b0, 1'b1);
        default: e = g(c[2], !c[2], c[2], !c[2]);
      endcase
      drive(c[1], c[0], 2'h0, 1'b0);
      chk("pwm", gate_on, e);
    end
    driver_enable_bit = 1'b0;
    drive(1'b1, 1'b0, 2'h0, 1'b0);
    chk("pwm_dis", gate_on, 4'h0);
    driver_enable_bit = 1'b1;
    freewheel_sel = 1'b0;
    $display("test pwm done");
  endtask : t_pwm
  // Split solenoid: only high one and low two follow their inputs.
  task automatic t_sol;
    bridge_mode_sel = 2'h3;
    reg_float_bit = 2'h3;
    for (int c = 0; c < 4; c++) begin
      drive(c[1], c[0], 2'h0, 1'b0);
      chk("sol", gate_on, g(c[1], 1'b0, 1'b0, c[0]));
    end
    drive(1'b1, 1'b1, 2'h3, 1'b1);
    chk("sol_off", gate_on, 4'h0);
    reg_float_bit = 2'h0;
    $display("test sol done");
  endtask : t_sol
  // Register-held controls, then a pin-configured part taking its mode pin.
  task automatic t_src;
    bridge_mode_sel = 2'h0;
    {ctrl_one_source_sel, ctrl_two_source_sel, reg_ctrl_one} = 3'h7;
    drive(1'b0, 1'b1, 2'h3, 1'b0);
    chk("src", gate_on, g(1'b1, 1'b0, 1'b0, 1'b1));
    {ctrl_one_source_sel, ctrl_two_source_sel, serial_variant} = 3'h0;
    bridge_mode_sel = 2'h3;
    mode_pin_level = 2'h1;
    drive(1'b1, 1'b1, 2'h3, 1'b0);
    chk("pin_mode", gate_on, g(1'b1, 1'b0, 1'b0, 1'b1));
    $display("test src done");
  endtask : t_src
  // ---------------------------------------------------------------
  // Sequence and watchdog.
  // ---------------------------------------------------------------
  // The tests need about 310 cycles; 5000 leaves a wide margin.
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    end_sim();
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_half();
    t_phen();
    t_pwm();
    t_sol();
    t_src();
    end_sim();
  end
endmodule : tb_top
